// ===== src/sief_apb_front.sv
// apb slave front end: zero-wait access phase, read data captured in setup.
// assumes the owner supplies read data and a hit flag for the current paddr.
`timescale 1ns/1ns
module sief_apb_front (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [sief_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                pwdata,
  input  wire logic [31:0]                rd_data,
  input  wire logic                       rd_hit,
  output logic                            pready,
  output logic                            pslverr,
  output logic [31:0]                     prdata,
  output sief_pkg::sief_reg_acc_t         acc
);

  typedef struct packed {
    logic [31:0] prdata;
    logic        miss;
  } sief_front_state_t;

  sief_front_state_t s;
  sief_front_state_t next_s;

  // capture read data and the decode result in the setup cycle
  always_comb begin
    next_s = s;
    if (psel && !penable) begin
      next_s.prdata = pwrite ? 32'h0 : rd_data;
      next_s.miss   = !rd_hit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // every access ends in its first access cycle
  assign pready    = 1'b1;
  assign pslverr   = psel && penable && s.miss;
  assign prdata    = s.prdata;
  assign acc.wr    = psel && penable && pwrite && !s.miss;
  assign acc.addr  = paddr;
  assign acc.wdata = pwdata;

endmodule : sief_apb_front

// ===== src/sief_bank.sv
// system interrupt enable and flag bank behind an apb slave.
// assumes presetn is the power-on reset and power_up_clear a one-cycle pulse
// from the reset logic; event inputs are synchronous one-cycle pulses except
// flash_viol_pending, which is a level held by the flash controller.
`timescale 1ns/1ns

module sief_bank (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [sief_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                 pwdata,
  output logic                             pready,
  output logic                             pslverr,
  output logic [31:0]                      prdata,
  input  wire logic                        power_up_clear,
  input  wire sief_pkg::sief_evt_t         evt,
  output sief_pkg::sief_irq_req_t          irq_req,
  output logic                             wdog_interval_mode,
  output logic                             pin_nmi_mode,
  output logic                             irq
);

  // bank state: enables, flags and pin / watchdog mode selection
  typedef struct packed {
    logic [7:0] enable;
    logic [7:0] flag;
    logic [1:0] mode;
  } sief_bank_state_t;

  sief_bank_state_t        s;
  sief_bank_state_t        next_s;
  sief_pkg::sief_reg_acc_t acc;
  logic [31:0]             rd_data;
  logic                    rd_hit;
  logic [sief_pkg::N_EVENTS-1:0] ev_set;
  logic [sief_pkg::N_EVENTS-1:0] st_status;
  logic [sief_pkg::N_EVENTS-1:0] st_mask;
  logic                    interval;
  logic                    nmi_mode;
  logic                    wdog_set;
  logic                    ext_rst;
  logic                    nmi_evt;
  logic                    wr_enable;
  logic                    wr_flag;
  logic                    wr_mode;
  logic                    wr_status;
  logic                    wr_mask;

  // bus front end
  sief_apb_front u_front (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .rd_data (rd_data),
    .rd_hit  (rd_hit),
    .pready  (pready),
    .pslverr (pslverr),
    .prdata  (prdata),
    .acc     (acc)
  );

  // write strobes per register
  assign wr_enable = acc.wr && (acc.addr == sief_pkg::ADDR_ENABLE_LOW);
  assign wr_flag   = acc.wr && (acc.addr == sief_pkg::ADDR_FLAG_LOW);
  assign wr_mode   = acc.wr && (acc.addr == sief_pkg::ADDR_MODE_CTRL);
  assign wr_status = acc.wr && (acc.addr == sief_pkg::ADDR_IRQ_STATUS);
  assign wr_mask   = acc.wr && (acc.addr == sief_pkg::ADDR_IRQ_MASK);

  // mode decode
  assign interval = s.mode[sief_pkg::MODE_WDOG_INTERVAL_BIT];
  assign nmi_mode = s.mode[sief_pkg::MODE_PIN_NMI_BIT];

  // event qualification by watchdog and pin mode
  assign wdog_set = (evt.wdog_overflow && !interval)
                  || evt.key_violation
                  || (evt.wdog_interval_tick && interval);
  assign ext_rst  = evt.rst_pin_event && !nmi_mode;
  assign nmi_evt  = evt.rst_pin_event && nmi_mode;

  // next state of enables, flags and mode
  always_comb begin
    next_s = s;
    // enables: only implemented positions store
    if (wr_enable) begin
      next_s.enable = acc.wdata[7:0] & sief_pkg::EN_IMPL_MASK;
    end
    if (power_up_clear) begin
      next_s.enable = sief_pkg::EN_RESET;
    end
    // flags: software writes, clearing by writing 0
    if (wr_flag) begin
      next_s.flag = acc.wdata[7:0] & sief_pkg::FLAG_IMPL_MASK;
    end
    // power-up clear touches only the plain-marked flag bits
    if (power_up_clear) begin
      next_s.flag = (next_s.flag & ~sief_pkg::FLAG_UPCLR_MASK)
                  | sief_pkg::FLAG_UPCLR_VALUE;
    end
    // a pin reset clears the watchdog flag before new events land
    if (ext_rst) begin
      next_s.flag[sief_pkg::FLAG_WDOG_BIT] = 1'b0;
    end
    // hardware sets win over any clear in the same cycle
    if (wdog_set) begin
      next_s.flag[sief_pkg::FLAG_WDOG_BIT] = 1'b1;
    end
    if (evt.osc_fault) begin
      next_s.flag[sief_pkg::FLAG_OSC_BIT] = 1'b1;
    end
    if (ext_rst) begin
      next_s.flag[sief_pkg::FLAG_EXT_BIT] = 1'b1;
    end
    if (nmi_evt) begin
      next_s.flag[sief_pkg::FLAG_NMI_BIT] = 1'b1;
    end
    // mode control
    if (wr_mode) begin
      next_s.mode = acc.wdata[1:0];
    end
    if (power_up_clear) begin
      next_s.mode = sief_pkg::MODE_RESET;
    end
  end

  // power-on reset loads every bit, bracketed ones included
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s.enable <= sief_pkg::EN_RESET;
      s.flag   <= sief_pkg::FLAG_POR_VALUE;
      s.mode   <= sief_pkg::MODE_RESET;
    end else begin
      s <= next_s;
    end
  end

  // read decode, narrow registers in the low bits
  always_comb begin
    rd_data = 32'h0;
    rd_hit  = 1'b1;
    unique case (paddr)
      sief_pkg::ADDR_ENABLE_LOW:  rd_data = {24'h0, s.enable};
      sief_pkg::ADDR_ENABLE_HIGH: rd_data = 32'h0;
      sief_pkg::ADDR_FLAG_LOW:    rd_data = {24'h0, s.flag};
      sief_pkg::ADDR_FLAG_HIGH:   rd_data = 32'h0;
      sief_pkg::ADDR_IRQ_STATUS:  rd_data = {27'h0, st_status};
      sief_pkg::ADDR_IRQ_MASK:    rd_data = {27'h0, st_mask};
      sief_pkg::ADDR_MODE_CTRL:   rd_data = {30'h0, s.mode};
      default:                    rd_hit  = 1'b0;
    endcase
  end

  // osc and nmi requests stay up while flag and enable are both set; wdog also needs interval mode; flash_viol is pending level and enable
  assign irq_req.wdog       = s.flag[sief_pkg::FLAG_WDOG_BIT]
                            && s.enable[sief_pkg::EN_WDOG_BIT] && interval;
  assign irq_req.osc_fault  = s.flag[sief_pkg::FLAG_OSC_BIT]
                            && s.enable[sief_pkg::EN_OSC_BIT];
  assign irq_req.pin_nmi    = s.flag[sief_pkg::FLAG_NMI_BIT]
                            && s.enable[sief_pkg::EN_NMI_BIT];
  assign irq_req.flash_viol = evt.flash_viol_pending
                            && s.enable[sief_pkg::EN_FLASH_BIT];
  assign wdog_interval_mode = interval;
  assign pin_nmi_mode       = nmi_mode;

  // sticky event record for the summary interrupt
  always_comb begin
    ev_set                         = '0;
    ev_set[sief_pkg::ST_WDOG_BIT]  = wdog_set;
    ev_set[sief_pkg::ST_OSC_BIT]   = evt.osc_fault;
    ev_set[sief_pkg::ST_EXT_BIT]   = ext_rst;
    ev_set[sief_pkg::ST_NMI_BIT]   = nmi_evt;
    ev_set[sief_pkg::ST_FLASH_BIT] = evt.flash_viol_pending;
  end

  sief_sticky #(
    .W (sief_pkg::N_EVENTS)
  ) u_sticky (
    .pclk    (pclk),
    .presetn (presetn),
    .set     (ev_set),
    .clr_wr  (wr_status),
    .mask_wr (wr_mask),
    .wdata   (acc.wdata[sief_pkg::N_EVENTS-1:0]),
    .status  (st_status),
    .mask    (st_mask),
    .irq     (irq)
  );

endmodule : sief_bank

// ===== src/sief_pkg.sv
// package of the system interrupt enable / flag bank: offsets, bit positions,
// reset values and the structs that carry grouped signals.
// assumes a 32-bit apb slave with an 8-bit byte address.
package sief_pkg;

  // apb address width
  localparam int unsigned ADDR_W = 8;

  // printed register offsets, kept as word indices
  localparam int unsigned REG_IDX_ENABLE_LOW  = 0;
  localparam int unsigned REG_IDX_ENABLE_HIGH = 1;
  localparam int unsigned REG_IDX_FLAG_LOW    = 2;
  localparam int unsigned REG_IDX_FLAG_HIGH   = 3;

  // byte addresses, one aligned word per register
  localparam logic [ADDR_W-1:0] ADDR_ENABLE_LOW  = ADDR_W'(REG_IDX_ENABLE_LOW * 4);
  localparam logic [ADDR_W-1:0] ADDR_ENABLE_HIGH = ADDR_W'(REG_IDX_ENABLE_HIGH * 4);
  localparam logic [ADDR_W-1:0] ADDR_FLAG_LOW    = ADDR_W'(REG_IDX_FLAG_LOW * 4);
  localparam logic [ADDR_W-1:0] ADDR_FLAG_HIGH   = ADDR_W'(REG_IDX_FLAG_HIGH * 4);
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS  = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK    = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_MODE_CTRL   = 8'h18;

  // enable register bit positions
  localparam int unsigned EN_WDOG_BIT  = 0;
  localparam int unsigned EN_OSC_BIT   = 1;
  localparam int unsigned EN_NMI_BIT   = 4;
  localparam int unsigned EN_FLASH_BIT = 5;

  // flag register bit positions
  localparam int unsigned FLAG_WDOG_BIT = 0;
  localparam int unsigned FLAG_OSC_BIT  = 1;
  localparam int unsigned FLAG_PWR_BIT  = 2;
  localparam int unsigned FLAG_EXT_BIT  = 3;
  localparam int unsigned FLAG_NMI_BIT  = 4;

  // implemented bits, reset values and power-up clear behaviour
  localparam logic [7:0] EN_IMPL_MASK     = 8'h33;
  localparam logic [7:0] EN_RESET         = 8'h00;
  localparam logic [7:0] FLAG_IMPL_MASK   = 8'h1f;
  localparam logic [7:0] FLAG_POR_VALUE   = 8'h06;
  localparam logic [7:0] FLAG_UPCLR_MASK  = 8'h12;
  localparam logic [7:0] FLAG_UPCLR_VALUE = 8'h02;

  // sticky event status bit positions
  localparam int unsigned ST_WDOG_BIT  = 0;
  localparam int unsigned ST_OSC_BIT   = 1;
  localparam int unsigned ST_EXT_BIT   = 2;
  localparam int unsigned ST_NMI_BIT   = 3;
  localparam int unsigned ST_FLASH_BIT = 4;
  localparam int unsigned N_EVENTS     = 5;
  localparam logic [N_EVENTS-1:0] ST_RESET   = 5'h00;
  localparam logic [N_EVENTS-1:0] MASK_RESET = 5'h00;

  // mode control bit positions
  localparam int unsigned MODE_WDOG_INTERVAL_BIT = 0;
  localparam int unsigned MODE_PIN_NMI_BIT       = 1;
  localparam logic [1:0]  MODE_RESET             = 2'h0;

  // system events arriving from neighbouring blocks
  typedef struct packed {
    logic wdog_overflow;
    logic wdog_interval_tick;
    logic key_violation;
    logic osc_fault;
    logic rst_pin_event;
    logic flash_viol_pending;
  } sief_evt_t;

  // per-source interrupt requests towards the cpu
  typedef struct packed {
    logic wdog;
    logic osc_fault;
    logic pin_nmi;
    logic flash_viol;
  } sief_irq_req_t;

  // register access decoded from the apb access phase
  typedef struct packed {
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
  } sief_reg_acc_t;

endpackage : sief_pkg

// ===== src/sief_sticky.sv
// sticky event status with write-one-to-clear, mask and one level interrupt.
// assumes set pulses and write strobes are synchronous to pclk.
`timescale 1ns/1ns
module sief_sticky #(
  parameter int unsigned W = 5
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] set,
  input  wire logic         clr_wr,
  input  wire logic         mask_wr,
  input  wire logic [W-1:0] wdata,
  output logic [W-1:0]      status,
  output logic [W-1:0]      mask,
  output logic              irq
);

  typedef struct packed {
    logic [W-1:0] status;
    logic [W-1:0] mask;
  } sief_sticky_state_t;

  sief_sticky_state_t s;
  sief_sticky_state_t next_s;

  // a set in the clearing cycle wins over the clear
  always_comb begin
    next_s = s;
    if (clr_wr) begin
      next_s.status = s.status & ~wdata;
    end
    next_s.status = next_s.status | set;
    if (mask_wr) begin
      next_s.mask = wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign status = s.status;
  assign mask   = s.mask;
  assign irq    = |(s.status & s.mask); // level while any unmasked bit stands

endmodule : sief_sticky

// ===== testbench/sief_bank_checker.sv
// assertions on the ports of sief_bank, attached by bind.
// assumes one pclk domain and an asynchronous active-low presetn.
`timescale 1ns/1ns
module sief_bank_checker (
  input wire logic                    pclk,
  input wire logic                    presetn,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [7:0]              paddr,
  input wire logic [31:0]             pwdata,
  input wire logic                    pready,
  input wire logic                    pslverr,
  input wire logic [31:0]             prdata,
  input wire logic                    power_up_clear,
  input wire sief_pkg::sief_evt_t     evt,
  input wire sief_pkg::sief_irq_req_t irq_req,
  input wire logic                    wdog_interval_mode,
  input wire logic                    pin_nmi_mode,
  input wire logic                    irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // access phase decode
  wire acc_rd = psel && penable && !pwrite;
  wire acc_wr = psel && penable && pwrite;
  a_wdog_mode_gate: assert property (
    irq_req.wdog |-> wdog_interval_mode) else $error("wdog request in watchdog mode");
  a_flash_lvl_gate: assert property (
    irq_req.flash_viol |-> evt.flash_viol_pending) else $error("flash request without event");
  a_en_spare_zero: assert property (
    acc_rd && paddr == sief_pkg::ADDR_ENABLE_LOW |-> (prdata & ~32'h33) == 32'h0)
    else $error("spare enable bit read set");
  a_flag_spare_zero: assert property (
    acc_rd && paddr == sief_pkg::ADDR_FLAG_LOW |-> (prdata & ~32'h1f) == 32'h0)
    else $error("spare flag bit read set");
  a_high_read_zero: assert property (
    acc_rd && (paddr == sief_pkg::ADDR_ENABLE_HIGH || paddr == sief_pkg::ADDR_FLAG_HIGH)
    |-> prdata == 32'h0) else $error("high register read not zero");
  a_upclr_mode_clear: assert property (
    power_up_clear |=> !wdog_interval_mode && !pin_nmi_mode) else $error("mode kept over clear");
  a_upclr_req_drop: assert property (
    power_up_clear |=> irq_req == 4'h0) else $error("request kept over clear");
  a_osc_req_holds: assert property (
    irq_req.osc_fault && !acc_wr && !power_up_clear |=> irq_req.osc_fault)
    else $error("osc request dropped");
endmodule : sief_bank_checker

// ===== testbench/sief_bank_tb.sv
// self-checking bench for sief_bank: apb tasks, event pulses, register checks.
// assumes the bank answers each apb access once pready is seen high.
`timescale 1ns/1ns
module sief_bank_tb;
  localparam logic [7:0] AEN = sief_pkg::ADDR_ENABLE_LOW;
  localparam logic [7:0] AEH = sief_pkg::ADDR_ENABLE_HIGH;
  localparam logic [7:0] AFL = sief_pkg::ADDR_FLAG_LOW;
  localparam logic [7:0] AFH = sief_pkg::ADDR_FLAG_HIGH;
  localparam logic [7:0] AST = sief_pkg::ADDR_IRQ_STATUS;
  localparam logic [7:0] AMK = sief_pkg::ADDR_IRQ_MASK;
  localparam logic [7:0] AMD = sief_pkg::ADDR_MODE_CTRL;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, power_up_clear;
  logic wdog_interval_mode, pin_nmi_mode, irq, rerr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  sief_pkg::sief_evt_t evt;
  sief_pkg::sief_irq_req_t irq_req;
  int error_cnt, comparisons;
  sief_bank dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .power_up_clear(power_up_clear), .evt(evt),
    .irq_req(irq_req), .wdog_interval_mode(wdog_interval_mode),
    .pin_nmi_mode(pin_nmi_mode), .irq(irq));
  // 20 MHz clock
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one apb transfer; data and error taken at the pready edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 16) begin
      error_cnt++;
      end_sim();
    end
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rdat);
  endtask : rd
  // one-cycle event pulse
  task automatic ev(input logic [5:0] e);
    @(posedge pclk);
    evt <= e;
    @(posedge pclk);
    evt <= 6'h00;
  endtask : ev
  // main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    power_up_clear = 1'b0;
    evt = 6'h00;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd("enable", AEN, 32'h0);
    rd("flag", AFL, 32'h06);
    rd("enable_hi", AEH, 32'h0);
    rd("flag_hi", AFH, 32'h0);
    rd("mode", AMD, 32'h0);
    wr(AEN, 32'hffffffff);
    rd("enable", AEN, 32'h33);
    wr(AEH, 32'hff);
    rd("enable_hi", AEH, 32'h0);
    wr(AFH, 32'hff);
    rd("flag_hi", AFH, 32'h0);
    rd("enable_hi", AEH, 32'h0);
    wr(AFL, 32'hff);
    rd("flag", AFL, 32'h1f);
    wr(AFL, 32'h0);
    rd("flag", AFL, 32'h0);
    wr(AFL, 32'h1f);
    wr(AMD, 32'h3);
    @(posedge pclk);
    power_up_clear <= 1'b1;
    @(posedge pclk);
    power_up_clear <= 1'b0;
    rd("flag", AFL, 32'h0f);
    rd("mode", AMD, 32'h0);
    rd("enable", AEN, 32'h0);
    wr(AFL, 32'h0);
    wr(AEN, 32'h01);
    ev(6'h20);
    rd("flag", AFL, 32'h01);
    @(negedge pclk);
    chk("irq_req", 32'h0, {28'h0, irq_req});
    wr(AMD, 32'h1);
    @(negedge pclk);
    chk("irq_req", 32'h8, {28'h0, irq_req});
    chk("interval_mode", 32'h1, {31'h0, wdog_interval_mode});
    wr(AFL, 32'h0);
    ev(6'h20);
    rd("flag", AFL, 32'h0);
    ev(6'h08);
    rd("flag", AFL, 32'h01);
    wr(AFL, 32'h0);
    ev(6'h10);
    rd("flag", AFL, 32'h01);
    wr(AMD, 32'h0);
    wr(AFL, 32'h0);
    ev(6'h10);
    rd("flag", AFL, 32'h0);
    ev(6'h02);
    rd("flag", AFL, 32'h08);
    wr(AMD, 32'h2);
    wr(AFL, 32'h0);
    chk("nmi_mode", 32'h1, {31'h0, pin_nmi_mode});
    chk("interval_mode", 32'h0, {31'h0, wdog_interval_mode});
    ev(6'h02);
    rd("flag", AFL, 32'h10);
    wr(AEN, 32'h10);
    @(negedge pclk);
    chk("irq_req", 32'h2, {28'h0, irq_req});
    wr(AFL, 32'h0);
    ev(6'h04);
    rd("flag", AFL, 32'h02);
    rd("status", AST, 32'h0f);
    wr(AMK, 32'h1f);
    @(negedge pclk);
    chk("irq", 32'h1, {31'h0, irq});
    wr(AST, 32'h0f);
    rd("status", AST, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
    ev(6'h04);
    @(negedge pclk);
    chk("irq", 32'h1, {31'h0, irq});
    wr(AMK, 32'h0);
    @(negedge pclk);
    chk("irq", 32'h0, {31'h0, irq});
    rd("status", AST, 32'h02);
    wr(AEN, 32'h20);
    @(posedge pclk);
    evt <= 6'h01;
    @(negedge pclk);
    chk("irq_req", 32'h1, {28'h0, irq_req});
    @(posedge pclk);
    evt <= 6'h00;
    rd("status", AST, 32'h12);
    apb(1'b0, 8'h1c, 32'h0);
    chk("pslverr", 32'h1, {31'h0, rerr});
    chk("unmapped", 32'h0, rdat);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd("flag", AFL, 32'h06);
    rd("enable", AEN, 32'h0);
    rd("mode", AMD, 32'h0);
    rd("status", AST, 32'h0);
    end_sim();
  end
endmodule : sief_bank_tb
bind sief_bank sief_bank_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .prdata(prdata), .power_up_clear(power_up_clear), .evt(evt),
  .irq_req(irq_req), .wdog_interval_mode(wdog_interval_mode),
  .pin_nmi_mode(pin_nmi_mode), .irq(irq));
